//--- core/utrf_params.svh
// timing counts, sizes and field encodings of the serial transmitter and receiver
`ifndef UTRF_PARAMS_SVH
`define UTRF_PARAMS_SVH
// =====================================================
// buffer sizes
`define UTRF_FIFO_DEPTH 4
`define UTRF_RXIRQ_MID 3
// =====================================================
// baud timing: sixteen baud ticks make one bit period
`define UTRF_PH_LAST 4'hF
`define UTRF_PH_MID 4'h7
`define UTRF_DIV_RESET 16'h0000
// =====================================================
// data and parity select encodings
`define UTRF_DPS_8N 2'h0
`define UTRF_DPS_8E 2'h1
`define UTRF_DPS_8O 2'h2
`define UTRF_DPS_9N 2'h3
// =====================================================
// frame layout: bit index of the first stop bit behind the start bit
`define UTRF_STOP_AT_8N 4'h8
`define UTRF_STOP_AT_PAR 4'h9
`define UTRF_FRAME_BASE 4'h9
`endif

//--- core/utrf_pkg.sv
// shared types of the serial transmitter and receiver
package utrf_pkg;
  typedef logic [8:0] utrf_word_t;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_WAIT_HIGH = 2'b11
  } utrf_rx_state_e;
endpackage

//--- core/utrf_core.sv
// asynchronous serial transmitter and receiver with four-deep buffers
//
// What this block does
// - written byte loads idle shifter on the next clock when enabled
// - four-entry transmit buffer with full flag
// - write to full transmit buffer is dropped
// - reset empties both buffers
// - transmit interrupt per move or on emptying
// - send break forces transmit line low
// - break never raises the transmit interrupt
// - four-word receive buffer behind the shifter
// - data available means receive buffer not empty
// - reading an empty buffer changes nothing
// - read pops and refreshes framing, parity bits
// - receive interrupt on every transfer, selects 0x
// - select 10 at three words, 11 full
// - overrun flag stops reception until cleared
// - framing error when any stop bit low
// - parity error checked when parity is selected
// - receiver idle low from start to stop
// - long break loads zero word with framing error
// - after break wait for high line first
// - address words always interrupt in nine-bit mode with address detect enabled
// - transmit pin rests high when not sending
// - eight bits with or without parity, or nine bits
`timescale 1ns/1ps
`include "utrf_params.svh"
module utrf_core #(
  parameter int DEPTH = `UTRF_FIFO_DEPTH
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // configuration
  input wire logic MODULE_ON,
  input wire logic TRANSMIT_ENABLE,
  input wire logic [1:0] DATA_PARITY_SELECT,
  input wire logic STOP_SELECT,
  input wire logic [15:0] BAUD_DIVISOR,
  input wire logic TRANSMIT_IRQ_SELECT,
  input wire logic [1:0] RECEIVE_IRQ_SELECT,
  input wire logic ADDRESS_DETECT_ENABLE,
  input wire logic SEND_BREAK_BIT,
  // transmit holding register write
  input wire logic TX_WRITE,
  input wire utrf_pkg::utrf_word_t TRANSMIT_HOLDING_REGISTER,
  // receive data register read and overrun clear
  input wire logic RX_READ,
  input wire logic OVERRUN_CLEAR,
  // serial line
  input wire logic RECEIVE_PIN,
  output logic TRANSMIT_PIN,
  // status and interrupt edges
  output logic TRANSMIT_FULL_FLAG,
  output logic TRANSMIT_SHIFTER_EMPTY,
  output logic TRANSMIT_IRQ_FLAG,
  output logic RECEIVE_IRQ_FLAG,
  output logic RECEIVE_DATA_AVAILABLE,
  output utrf_pkg::utrf_word_t RECEIVE_DATA_REGISTER,
  output logic FRAMING_ERROR_BIT,
  output logic PARITY_ERROR_BIT,
  output logic OVERRUN_FLAG,
  output logic RECEIVER_IDLE_BIT
);
  import utrf_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] MID_LEVEL = CW'(`UTRF_RXIRQ_MID);

  // =====================================================
  // helpers

  // bits after the start bit: data, parity or ninth bit, stop bits
  function automatic logic [3:0] frame_bits(input logic [1:0] dps, input logic two);
    frame_bits = `UTRF_FRAME_BASE + {3'h0, two} + ((dps == `UTRF_DPS_8N) ? 4'h0 : 4'h1);
  endfunction

  // bit sent after the low byte: parity, ninth data bit or a stop
  function automatic logic ninth_bit(input utrf_word_t w, input logic [1:0] dps);
    case (dps)
      `UTRF_DPS_8E: ninth_bit = ^w[7:0];
      `UTRF_DPS_8O: ninth_bit = ~^w[7:0];
      `UTRF_DPS_9N: ninth_bit = w[8];
      default: ninth_bit = 1'h1;
    endcase
  endfunction

  // switching the module off flushes buffers and flags like a reset
  wire clr = RESET | ~MODULE_ON;

  // =====================================================
  // baud tick divider
  logic [15:0] div_r;
  wire tick = (div_r == BAUD_DIVISOR);

  always_ff @(posedge CLK_SYS) begin
    if (clr || tick) begin
      div_r <= `UTRF_DIV_RESET;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // =====================================================
  // transmit buffer and shifter
  utrf_word_t tx_mem_r [DEPTH];
  logic [PW-1:0] tx_wr_r;
  logic [PW-1:0] tx_rd_r;
  logic [CW-1:0] tx_cnt_r;
  logic tx_busy_r;
  logic [11:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic [3:0] tx_ph_r;

  wire tx_full = (tx_cnt_r == FULL);
  wire tx_push = TX_WRITE & ~tx_full;
  // holding off during break keeps a queued word from being mangled
  wire tx_load = ~tx_busy_r & TRANSMIT_ENABLE & (tx_cnt_r != '0) & ~SEND_BREAK_BIT;
  wire [CW-1:0] tx_cnt_nxt = tx_cnt_r + CW'(tx_push) - CW'(tx_load);
  wire tx_bit_end = tx_busy_r & tick & (tx_ph_r == `UTRF_PH_LAST);
  wire tx_last = tx_bit_end & (tx_left_r == 4'h1);
  wire tx_busy_nxt = tx_load | (tx_busy_r & ~tx_last);
  wire utrf_word_t tx_head = tx_mem_r[tx_rd_r];
  wire [11:0] tx_frame = {2'h3, ninth_bit(tx_head, DATA_PARITY_SELECT), tx_head[7:0], 1'h0};
  wire [11:0] tx_sh_nxt = tx_load ? tx_frame : (tx_bit_end ? {1'h1, tx_sh_r[11:1]} : tx_sh_r);
  wire tx_irq = tx_load & (~TRANSMIT_IRQ_SELECT | (tx_cnt_nxt == '0));
  wire tx_pin_nxt = ~SEND_BREAK_BIT & (~tx_busy_nxt | tx_sh_nxt[0]);

  always_ff @(posedge CLK_SYS) begin
    if (clr) begin
      tx_wr_r <= '0;
      tx_rd_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) begin
        tx_mem_r[tx_wr_r] <= TRANSMIT_HOLDING_REGISTER;
        tx_wr_r <= PW'(tx_wr_r + 1'h1);
      end
      if (tx_load) begin
        tx_rd_r <= PW'(tx_rd_r + 1'h1);
      end
      tx_cnt_r <= tx_cnt_nxt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (clr) begin
      tx_busy_r <= 1'h0;
      tx_sh_r <= 12'hFFF;
      tx_left_r <= 4'h0;
      tx_ph_r <= 4'h0;
    end else begin
      tx_busy_r <= tx_busy_nxt;
      tx_sh_r <= tx_sh_nxt;
      if (tx_load) begin
        tx_left_r <= frame_bits(DATA_PARITY_SELECT, STOP_SELECT) + 4'h1;
        tx_ph_r <= 4'h0;
      end else begin
        if (tx_bit_end) begin
          tx_left_r <= tx_left_r - 4'h1;
        end
        if (tx_busy_r && tick) begin
          tx_ph_r <= tx_ph_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (clr) begin
      TRANSMIT_PIN <= 1'h1;
      TRANSMIT_FULL_FLAG <= 1'h0;
      TRANSMIT_SHIFTER_EMPTY <= 1'h1;
      TRANSMIT_IRQ_FLAG <= 1'h0;
    end else begin
      TRANSMIT_PIN <= tx_pin_nxt;
      TRANSMIT_FULL_FLAG <= (tx_cnt_nxt == FULL);
      TRANSMIT_SHIFTER_EMPTY <= ~tx_busy_nxt & (tx_cnt_nxt == '0);
      TRANSMIT_IRQ_FLAG <= tx_irq;
    end
  end

  // =====================================================
  // receive shifter
  utrf_rx_state_e rx_st_r;
  logic [3:0] rx_ph_r;
  logic [3:0] rx_idx_r;
  logic [11:0] rx_bits_r;
  logic [11:0] rx_frame;

  always_comb begin
    rx_frame = rx_bits_r;
    rx_frame[rx_idx_r] = RECEIVE_PIN;
  end

  wire [3:0] rx_nb = frame_bits(DATA_PARITY_SELECT, STOP_SELECT);
  wire rx_take = (rx_st_r == RX_BITS) & tick & (rx_ph_r == `UTRF_PH_LAST);
  wire rx_done = rx_take & (rx_idx_r == rx_nb - 4'h1);
  wire [3:0] rx_stop_at = (DATA_PARITY_SELECT == `UTRF_DPS_8N) ? `UTRF_STOP_AT_8N : `UTRF_STOP_AT_PAR;
  wire rx_fe = ~rx_frame[rx_stop_at] | (STOP_SELECT & ~rx_frame[rx_stop_at + 4'h1]);
  wire rx_is9 = (DATA_PARITY_SELECT == `UTRF_DPS_9N);
  wire utrf_word_t rx_word = {rx_is9 & rx_frame[8], rx_frame[7:0]};
  wire rx_par = (DATA_PARITY_SELECT == `UTRF_DPS_8E) | (DATA_PARITY_SELECT == `UTRF_DPS_8O);
  wire rx_pe = rx_par & (rx_frame[8] != ninth_bit({1'h0, rx_frame[7:0]}, DATA_PARITY_SELECT));

  always_ff @(posedge CLK_SYS) begin
    if (clr) begin
      rx_st_r <= RX_HUNT;
      rx_ph_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_bits_r <= 12'h000;
      RECEIVER_IDLE_BIT <= 1'h1;
    end else begin
      case (rx_st_r)
        RX_HUNT: begin
          if (!RECEIVE_PIN && !OVERRUN_FLAG) begin
            rx_st_r <= RX_START;
            rx_ph_r <= 4'h0;
            RECEIVER_IDLE_BIT <= 1'h0;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (rx_ph_r == `UTRF_PH_MID) begin
              // a start bit gone high at its middle was a glitch
              rx_st_r <= RECEIVE_PIN ? RX_HUNT : RX_BITS;
              RECEIVER_IDLE_BIT <= RECEIVE_PIN;
              rx_ph_r <= 4'h0;
              rx_idx_r <= 4'h0;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_ph_r <= rx_ph_r + 4'h1;
          end
          if (rx_take) begin
            rx_bits_r <= rx_frame;
            rx_idx_r <= rx_idx_r + 4'h1;
          end
          if (rx_done) begin
            rx_st_r <= rx_fe ? RX_WAIT_HIGH : RX_HUNT;
            RECEIVER_IDLE_BIT <= 1'h1;
          end
        end
        RX_WAIT_HIGH: begin
          if (RECEIVE_PIN) begin
            rx_st_r <= RX_HUNT;
          end
        end
        default: begin
          rx_st_r <= RX_HUNT;
        end
      endcase
    end
  end

  // =====================================================
  // receive buffer; each entry keeps its parity and framing bits
  logic [10:0] rx_mem_r [DEPTH];
  logic [PW-1:0] rx_wr_r;
  logic [PW-1:0] rx_rd_r;
  logic [CW-1:0] rx_cnt_r;

  wire rx_full = (rx_cnt_r == FULL);
  wire rx_pop = RX_READ & (rx_cnt_r != '0);
  wire rx_push = rx_done & (~rx_full | rx_pop);
  wire rx_ovr_set = rx_done & rx_full & ~rx_pop;
  wire [CW-1:0] rx_cnt_nxt = rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
  wire [PW-1:0] rx_rd_nxt = rx_pop ? PW'(rx_rd_r + 1'h1) : rx_rd_r;
  wire [10:0] rx_entry = {rx_pe, rx_fe, rx_word};
  wire rx_bypass = rx_push & (rx_cnt_r == (rx_pop ? CW'(1) : CW'(0)));
  wire [10:0] rx_head_nxt = rx_bypass ? rx_entry : rx_mem_r[rx_rd_nxt];
  wire rx_show = rx_bypass | (rx_pop & (rx_cnt_nxt != '0));
  wire rx_addr = ADDRESS_DETECT_ENABLE & rx_is9;
  wire rx_level = RECEIVE_IRQ_SELECT[0] ? (rx_cnt_nxt == FULL) : (rx_cnt_nxt == MID_LEVEL);
  wire rx_irq = rx_push & (rx_addr ? rx_word[8] : (~RECEIVE_IRQ_SELECT[1] | rx_level));

  always_ff @(posedge CLK_SYS) begin
    if (clr) begin
      rx_wr_r <= '0;
      rx_rd_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (rx_push) begin
        rx_mem_r[rx_wr_r] <= rx_entry;
        rx_wr_r <= PW'(rx_wr_r + 1'h1);
      end
      rx_rd_r <= rx_rd_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (clr) begin
      RECEIVE_DATA_AVAILABLE <= 1'h0;
      RECEIVE_IRQ_FLAG <= 1'h0;
      RECEIVE_DATA_REGISTER <= 9'h000;
      FRAMING_ERROR_BIT <= 1'h0;
      PARITY_ERROR_BIT <= 1'h0;
      OVERRUN_FLAG <= 1'h0;
    end else begin
      RECEIVE_DATA_AVAILABLE <= (rx_cnt_nxt != '0);
      RECEIVE_IRQ_FLAG <= rx_irq;
      if (rx_show) begin
        {PARITY_ERROR_BIT, FRAMING_ERROR_BIT, RECEIVE_DATA_REGISTER} <= rx_head_nxt;
      end
      // a new overrun wins over a clear in the same cycle
      if (rx_ovr_set) begin
        OVERRUN_FLAG <= 1'h1;
      end else if (OVERRUN_CLEAR) begin
        OVERRUN_FLAG <= 1'h0;
      end
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  tx_full_a: assert property (TRANSMIT_FULL_FLAG == (tx_cnt_r == FULL))
    else $error("transmit full flag disagrees with buffer level");
  tx_drop_a: assert property (MODULE_ON && tx_full && TX_WRITE && !tx_load |=>
    tx_cnt_r == FULL && tx_wr_r == $past(tx_wr_r)) else $error("write to full buffer was taken");
  flush_a: assert property (disable iff (1'h0) RESET |=> tx_cnt_r == '0 && !RECEIVE_DATA_AVAILABLE)
    else $error("reset left data in a buffer");
  tx_irq_a: assert property (MODULE_ON && tx_load && !TRANSMIT_IRQ_SELECT |=> TRANSMIT_IRQ_FLAG)
    else $error("transmit interrupt missing on load");
  tx_quiet_a: assert property (!tx_load |=> !TRANSMIT_IRQ_FLAG)
    else $error("transmit interrupt without a load");
  break_low_a: assert property (MODULE_ON && SEND_BREAK_BIT |=> !TRANSMIT_PIN)
    else $error("line not low during break");
  idle_pin_a: assert property (MODULE_ON && !SEND_BREAK_BIT && !tx_busy_nxt |=> TRANSMIT_PIN)
    else $error("idle transmit line not high");
  rx_avail_a: assert property (RECEIVE_DATA_AVAILABLE == (rx_cnt_r != '0))
    else $error("data available disagrees with buffer level");
  empty_read_a: assert property (MODULE_ON && RX_READ && rx_cnt_r == '0 && !rx_push |=>
    $stable(RECEIVE_DATA_REGISTER)) else $error("empty read changed the data");
  rx_full_irq_a: assert property (MODULE_ON && rx_push && !rx_addr && RECEIVE_IRQ_SELECT == 2'h3 |=>
    RECEIVE_IRQ_FLAG == (rx_cnt_r == FULL)) else $error("full level interrupt wrong");
  overrun_a: assert property (MODULE_ON && rx_ovr_set |=> OVERRUN_FLAG && rx_st_r != RX_START)
    else $error("overrun not flagged or reception went on");
  break_wait_a: assert property (MODULE_ON && rx_done && rx_fe |=>
    rx_st_r == RX_WAIT_HIGH && RECEIVER_IDLE_BIT) else $error("receiver not waiting for high line");

  tx_frame_c: cover property (tx_last);
  rx_push_c: cover property (rx_push && rx_fe);
  overrun_c: cover property (rx_ovr_set);
endmodule

//--- verif/utrf_station.sv
// remote serial station: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
module utrf_station (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic tx_line,
  output logic rx_line
);
  // line idles high between frames
  initial rx_line = 1'b1;
  // ==========================================
  // sending: one bit is sixteen clocks, divisor held at zero
  task automatic hold(input logic v, input int bits);
    rx_line <= v;
    repeat (16 * bits) @(posedge clk);
  endtask
  task automatic send(input logic [8:0] w, input logic [1:0] dps, input logic bad_par, input logic bad_stop);
    logic p;
    p = (dps == 2'h1) ? ^w[7:0] : (dps == 2'h2) ? ~^w[7:0] : w[8];
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(w[i], 1);
    if (dps != 2'h0) hold(p ^ bad_par, 1);
    hold(~bad_stop, 1);
    hold(1'b1, 1);
  endtask
  // eight data bits, no parity, two stop bits; the second may be forced low
  task automatic send_two(input logic [7:0] d, input logic bad_second);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(d[i], 1);
    hold(1'b1, 1);
    hold(~bad_second, 1);
    hold(1'b1, 1);
  endtask
  // break longer than thirteen bit times, then a valid high
  task automatic brk();
    hold(1'b0, 14);
    hold(1'b1, 2);
  endtask
  // ==========================================
  // receiving: samples n bits at mid-bit after the start edge
  task automatic get(input int n, output logic [9:0] bits);
    bits = '0;
    while (tx_line !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clk);
      bits[i] = tx_line;
    end
  endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench of the serial transmitter and receiver
`timescale 1ns/1ps
module tb_top;
  import utrf_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ten = 1'b1, txsel = 1'b0, address_detect_enable = 1'b0, brk = 1'b0, stop_select = 1'b0;
  logic [1:0] dps = 2'h0, rxsel = 2'h0;
  logic tx_write = 1'b0, rx_read = 1'b0, ov_clr = 1'b0;
  utrf_word_t thr = '0;
  logic rx_line, tx_pin, full, sh_empty, tx_irq, rx_irq, avail, fe, pe, ovr, idle;
  utrf_word_t rdr;
  logic [9:0] got;
  int num_errors = 0, samples_checked = 0, tx_irqs = 0, rx_irqs = 0, cycles = 0;
  initial forever #25 clk = ~clk;
  utrf_core dut_u (
    .CLK_SYS(clk),
    .RESET(rst),
    .MODULE_ON(1'b1),
    .TRANSMIT_ENABLE(ten),
    .DATA_PARITY_SELECT(dps),
    .STOP_SELECT(stop_select),
    .BAUD_DIVISOR(16'h0000),
    .TRANSMIT_IRQ_SELECT(txsel),
    .RECEIVE_IRQ_SELECT(rxsel),
    .ADDRESS_DETECT_ENABLE(address_detect_enable),
    .SEND_BREAK_BIT(brk),
    .TX_WRITE(tx_write),
    .TRANSMIT_HOLDING_REGISTER(thr),
    .RX_READ(rx_read),
    .OVERRUN_CLEAR(ov_clr),
    .RECEIVE_PIN(rx_line),
    .TRANSMIT_PIN(tx_pin),
    .TRANSMIT_FULL_FLAG(full),
    .TRANSMIT_SHIFTER_EMPTY(sh_empty),
    .TRANSMIT_IRQ_FLAG(tx_irq),
    .RECEIVE_IRQ_FLAG(rx_irq),
    .RECEIVE_DATA_AVAILABLE(avail),
    .RECEIVE_DATA_REGISTER(rdr),
    .FRAMING_ERROR_BIT(fe),
    .PARITY_ERROR_BIT(pe),
    .OVERRUN_FLAG(ovr),
    .RECEIVER_IDLE_BIT(idle)
  );
  utrf_station stn_u (
    .clk(clk),
    .tx_line(tx_pin),
    .rx_line(rx_line)
  );
  // ==========================================
  // helpers; interrupt pulses are counted at the falling edge to stay clear of drive races
  always @(negedge clk) begin
    cycles++;
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input utrf_word_t w);
    thr <= w;
    tx_write <= 1'b1;
    @(posedge clk);
    tx_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd();
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    @(posedge clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    check("tx pin", 1, tx_pin);
    check("rx idle", 1, idle);
    check("rx avail", 0, avail);
    check("tx full", 0, full);
  endtask
  task automatic t_tx_modes();
    logic [7:0] d;
    logic [9:0] e;
    for (int m = 0; m < 4; m++) begin
      dps <= 2'(m);
      d = 8'h5A + 8'(m);
      e = {1'b1, (m == 1) ? ^d : (m == 2) ? ~^d : 1'b1, d};
      if (m == 0) e = {2'b01, d};
      tx_irqs = 0;
      @(posedge clk);
      wr({1'b1, d});
      stn_u.get((m == 0) ? 9 : 10, got);
      check("tx frame", e, got);
      check("tx irq per load", 1, tx_irqs);
    end
  endtask
  task automatic t_tx_fifo();
    utrf_word_t w[5];
    dps <= 2'h0;
    txsel <= 1'b1;
    ten <= 1'b0;
    tx_irqs = 0;
    for (int i = 0; i < 5; i++) begin
      w[i] = 9'h030 + 9'(i);
      wr(w[i]);
      if (i >= 3) check("tx full", 1, full);
    end
    ten <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      stn_u.get(9, got);
      check("tx order", {2'b01, w[i][7:0]}, got);
    end
    repeat (40) @(posedge clk);
    check("tx drained", 1, sh_empty);
    check("tx pin rest", 1, tx_pin);
    check("tx irq on empty", 1, tx_irqs);
    txsel <= 1'b0;
  endtask
  task automatic t_break();
    tx_irqs = 0;
    wr(9'h0F0);
    // software waits for an idle transmitter before sending a break
    while (sh_empty !== 1'b1) @(posedge clk);
    brk <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      check("break low", 0, tx_pin);
      repeat (16) @(posedge clk);
    end
    brk <= 1'b0;
    repeat (480) @(posedge clk);
    check("break irq", 1, tx_irqs);
    check("tx pin after break", 1, tx_pin);
  endtask
  task automatic t_rx_fifo();
    rx_irqs = 0;
    for (int i = 0; i < 5; i++) begin
      rxsel <= (i < 3) ? 2'h2 : 2'h3;
      fork
        stn_u.send(9'h041 + 9'(i), 2'h0, 1'b0, 1'b0);
        begin
          repeat (64) @(posedge clk);
          check("rx busy", 0, idle);
        end
      join
      if (i == 2) check("rx irq at three", 1, rx_irqs);
    end
    check("rx irq at full", 2, rx_irqs);
    check("overrun", 1, ovr);
    fork
      stn_u.send(9'h07E, 2'h0, 1'b0, 1'b0);
      begin
        repeat (64) @(posedge clk);
        check("rx held off", 1, idle);
      end
    join
    for (int i = 0; i < 4; i++) begin
      check("rx avail", 1, avail);
      check("rx head", 9'h041 + 9'(i), rdr);
      rd();
    end
    check("rx empty", 0, avail);
    rd();
    check("rx empty read", 9'h044, rdr);
    ov_clr <= 1'b1;
    @(posedge clk);
    ov_clr <= 1'b0;
    @(posedge clk);
    check("overrun cleared", 0, ovr);
  endtask
  task automatic t_rx_err();
    dps <= 2'h1;
    rxsel <= 2'h0;
    rx_irqs = 0;
    @(posedge clk);
    stn_u.send(9'h0C3, 2'h1, 1'b1, 1'b0);
    stn_u.send(9'h03C, 2'h1, 1'b0, 1'b1);
    rxsel <= 2'h1;
    stn_u.brk();
    check("rx irq per push", 3, rx_irqs);
    check("rx idle after break", 1, idle);
    check("parity error", 2'b01, {fe, pe});
    check("rx head", 9'h0C3, rdr);
    rd();
    check("framing error", 2'b10, {fe, pe});
    rd();
    check("break word", 10'h200, {fe, rdr});
    rd();
    check("one break push", 0, avail);
  endtask
  task automatic t_addr();
    dps <= 2'h3;
    address_detect_enable <= 1'b1;
    rxsel <= 2'h3;
    ten <= 1'b0;
    rx_irqs = 0;
    wr(9'h011);
    stn_u.send(9'h13C, 2'h3, 1'b0, 1'b0);
    check("address irq", 1, rx_irqs);
    check("ninth bit", 9'h13C, rdr);
    stn_u.send(9'h0C3, 2'h3, 1'b0, 1'b0);
    check("data word irq", 1, rx_irqs);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset empties rx", 0, avail);
    check("reset empties tx", 1, sh_empty);
  endtask
  task automatic t_two_stop();
    stop_select <= 1'b1;
    dps <= 2'h0;
    ten <= 1'b1;
    address_detect_enable <= 1'b0;
    rxsel <= 2'h0;
    @(posedge clk);
    wr(9'h0A5);
    stn_u.get(10, got);
    check("two stop frame", 10'h3A5, got);
    check("second stop sent", 0, sh_empty);
    stn_u.send_two(8'h5A, 1'b1);
    check("second stop error", 10'h25A, {fe, rdr});
    rd();
    stn_u.send_two(8'h96, 1'b0);
    check("two stops clean", 10'h096, {fe, rdr});
    rd();
    stop_select <= 1'b0;
    dps <= 2'h2;
    @(posedge clk);
    stn_u.send(9'h0C3, 2'h2, 1'b1, 1'b0);
    check("odd parity error", 10'h2C3, {pe, rdr});
    rd();
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_tx_modes();
    t_tx_fifo();
    t_break();
    t_rx_fifo();
    t_rx_err();
    t_addr();
    t_two_stop();
    summarize();
  end
endmodule
